// ===== include/simd_move_pkg.sv
// Package: opcodes, widths and constants for the SIMD element move unit
`default_nettype none
package simd_move_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned VEC128_WIDTH = 128;
    localparam int unsigned VEC64_WIDTH = 64;
    localparam int unsigned SCALAR_WIDTH = 64;
    localparam int unsigned WORD_WIDTH = 16;
    localparam int unsigned SEL_WIDTH = 2;
    localparam int unsigned RESULT_LATENCY = 1;
    localparam logic [127:0] RESULT_RESET = 128'h0;
    localparam logic [63:0] SCALAR_RESET = 64'h0;

    // ------------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        op_nop,
        op_unpack_low,
        op_unpack_high,
        op_extract_word_64,
        op_extract_word_128,
        op_extract_byte,
        op_extract_dword,
        op_extract_qword,
        op_extract_float,
        op_insert_word_64,
        op_insert_word_128,
        op_insert_byte,
        op_insert_dword,
        op_insert_qword,
        op_insert_float,
        op_byte_mask_64,
        op_byte_mask_128,
        word_shuffle_op,
        low_word_shuffle_op,
        high_word_shuffle_op,
        dword_shuffle_op
    } op_type;

    // Element size of an unpack
    typedef enum logic [1:0] {
        elem_byte,
        elem_word,
        elem_dword,
        elem_qword
    } elem_type;
endpackage
`default_nettype wire

// ===== include/move_result_if.sv
// Interface: result bundle between the datapath and its writeback stage
`timescale 1ns/10ps
`default_nettype none
interface move_result_if;
    logic [127:0] vector;
    logic [63:0] scalar;
    logic vector_write;
    logic scalar_write;

    modport source
    (
        output vector,
        output scalar,
        output vector_write,
        output scalar_write
    );
    modport sink
    (
        input vector,
        input scalar,
        input vector_write,
        input scalar_write
    );
endinterface
`default_nettype wire

// ===== logic/shuffle_select.sv
// Module: four-lane selector steered by a control byte
`timescale 1ns/10ps
`default_nettype none
module shuffle_select #(
    parameter int unsigned LANE_WIDTH = 16
) (
    // Four source lanes, lane 0 lowest
    input wire logic [4*LANE_WIDTH-1:0] lanes_in,
    // Control byte
    input wire logic [7:0] control_byte,
    // Permuted lanes
    output logic [4*LANE_WIDTH-1:0] lanes_out
);
    // Each 2-bit field picks the source for one destination lane
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            wire logic [1:0] sel = control_byte[2*lane +: 2];
            assign lanes_out[lane*LANE_WIDTH +: LANE_WIDTH] =
                lanes_in[sel*LANE_WIDTH +: LANE_WIDTH];
        end
    endgenerate
endmodule // shuffle_select
`default_nettype wire

// ===== logic/byte_sign_mask.sv
// Module: gathers the top bit of each byte into a zero-extended mask
`timescale 1ns/10ps
`default_nettype none
module byte_sign_mask (
    // Source vector and width choice
    input wire logic [127:0] source,
    input wire logic wide,
    // Zero-extended mask
    output logic [31:0] mask
);
    logic [15:0] all_bits;

    // Bit n of the mask is the sign bit of byte n
    always_comb
    begin
        all_bits = '0;
        for (int b = 0; b < 16; b++)
        begin
            all_bits[b] = source[8*b+7];
        end
    end

    // Narrow form keeps only eight bits, the rest cleared
    assign mask = wide ? {16'h0000, all_bits}
                       : {24'h000000, all_bits[7:0]};
endmodule // byte_sign_mask
`default_nettype wire

// ===== logic/simd_element_move_unit.sv
// Module: single-cycle SIMD data-movement datapath
// Notes on behaviour
// - Unpack interleaves elements alternately from destination and source.
// - Narrow word extract picks word by imm[1:0], zero-extends into 64 bits.
// - Wide word extract puts the word in the lowest 16 scalar bits.
// - Extract byte, word, dword or qword from 128-bit vector to scalar/memory.
// - Narrow word insert writes low scalar word into lane imm[1:0].
// - Narrow word insert leaves the other three lanes unchanged.
// - Wide word insert takes the lowest 16 scalar bits.
// - Insert byte, dword or qword from scalar or memory into 128-bit vector.
// - Separate float and integer insert/extract, direct memory to vector.
// - Byte mask collects each byte's top bit, in byte order.
// - Narrow byte mask gives 8 bits and clears upper 24.
// - Wide byte mask gives 16 bits and clears upper 16.
// - 64-bit word shuffle picks each word from four source words.
// - Low word shuffle permutes the low four words.
// - High word shuffle permutes the high four words.
// - Dword shuffle permutes the four dwords.
// - Control byte is four 2-bit selectors, lane 0 in bits 1:0.
// - Unshuffled half of a low/high word shuffle passes unchanged.
`timescale 1ns/10ps
`default_nettype none
module simd_element_move_unit (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Issue
    input wire logic issue_valid,
    input wire simd_move_pkg::op_type op,
    input wire simd_move_pkg::elem_type unpack_size,
    input wire logic [7:0] control_byte,
    // Operands: destination vector, source vector or memory, scalar
    input wire logic [127:0] dest_operand,
    input wire logic [127:0] source_operand,
    input wire logic [63:0] scalar_operand,
    // Writeback
    output logic result_valid,
    output logic [127:0] vector_result,
    output logic [63:0] scalar_result,
    output logic vector_write,
    output logic scalar_write
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Interleave the low (or high) halves of two vectors at element size
    function automatic logic [127:0] interleave(input logic [127:0] d,
                                                input logic [127:0] s,
                                                input logic high,
                                                input simd_move_pkg::elem_type sz);
        logic [127:0] r;
        int w;
        int n;
        int base;
        r = '0;
        w = 8 << sz;
        n = 64 / w;
        base = high ? 64 : 0;
        for (int i = 0; i < 16; i++)
        begin
            if (i < n)
            begin
                for (int k = 0; k < 64; k++)
                begin
                    if (k < w)
                    begin
                        r[2*i*w + k] = d[base + i*w + k];
                        r[(2*i+1)*w + k] = s[base + i*w + k];
                    end
                end
            end
        end
        return r;
    endfunction

    // Insert an element of given byte size at a lane of a 128-bit vector
    function automatic logic [127:0] place(input logic [127:0] v,
                                           input logic [63:0] e,
                                           input int bytes,
                                           input logic [3:0] lane);
        logic [127:0] r;
        int off;
        r = v;
        off = int'(lane) * bytes * 8;
        for (int k = 0; k < 64; k++)
        begin
            if (k < bytes * 8)
            begin
                r[off + k] = e[k];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Decode of element lanes from the control byte
    // ------------------------------------------------------------------
    // Fields are cut to the lane count, so no lane can fall outside its register
    wire logic [1:0] word4_lane = control_byte[1:0];
    wire logic [2:0] word8_lane = control_byte[2:0];
    wire logic [3:0] byte_lane = control_byte[3:0];
    wire logic [1:0] dword_lane = control_byte[1:0];
    wire logic qword_lane = control_byte[0];

    // ------------------------------------------------------------------
    // Shuffles and mask
    // ------------------------------------------------------------------
    logic [63:0] shuf_low;
    logic [63:0] shuf_high;
    logic [127:0] shuf_dword;
    logic [31:0] sign_mask;
    wire logic wide_mask = (op == simd_move_pkg::op_byte_mask_128);

    // Low half also serves the 64-bit word shuffle
    shuffle_select #(.LANE_WIDTH(16)) u_low
    (
        .lanes_in(source_operand[63:0]),
        .control_byte(control_byte),
        .lanes_out(shuf_low)
    );
    shuffle_select #(.LANE_WIDTH(16)) u_high
    (
        .lanes_in(source_operand[127:64]),
        .control_byte(control_byte),
        .lanes_out(shuf_high)
    );
    shuffle_select #(.LANE_WIDTH(32)) u_dword
    (
        .lanes_in(source_operand),
        .control_byte(control_byte),
        .lanes_out(shuf_dword)
    );
    byte_sign_mask u_mask
    (
        .source(source_operand),
        .wide(wide_mask),
        .mask(sign_mask)
    );

    // ------------------------------------------------------------------
    // Result selection
    // ------------------------------------------------------------------
    // Next values of the writeback registers, bundled for the stage below
    logic [127:0] next_vector;
    logic [63:0] next_scalar;
    logic next_vwrite;
    logic next_swrite;
    move_result_if next_if();

    // One combinational mux; memory forms use the same scalar/vector paths
    always_comb
    begin
        next_vector = dest_operand;
        next_scalar = 64'h0;
        next_vwrite = 1'b0;
        next_swrite = 1'b0;
        case (op)
            simd_move_pkg::op_unpack_low,
            simd_move_pkg::op_unpack_high:
            begin
                next_vector = interleave(dest_operand, source_operand,
                    op == simd_move_pkg::op_unpack_high, unpack_size);
                next_vwrite = 1'b1;
            end
            simd_move_pkg::op_extract_word_64:
            begin
                next_scalar = {48'h0, source_operand[16*word4_lane +: 16]};
                next_swrite = 1'b1;
            end
            simd_move_pkg::op_extract_word_128:
            begin
                next_scalar = {48'h0, source_operand[16*word8_lane +: 16]};
                next_swrite = 1'b1;
            end
            simd_move_pkg::op_extract_byte:
            begin
                next_scalar = {56'h0, source_operand[8*byte_lane +: 8]};
                next_swrite = 1'b1;
            end
            simd_move_pkg::op_extract_dword,
            simd_move_pkg::op_extract_float:
            begin
                next_scalar = {32'h0, source_operand[32*dword_lane +: 32]};
                next_swrite = 1'b1;
            end
            simd_move_pkg::op_extract_qword:
            begin
                next_scalar = source_operand[64*qword_lane +: 64];
                next_swrite = 1'b1;
            end
            simd_move_pkg::op_insert_word_64:
            begin
                // Upper 64 bits are outside the narrow register and pass through
                next_vector = place(dest_operand, scalar_operand, 2,
                    {2'b00, word4_lane});
                next_vwrite = 1'b1;
            end
            simd_move_pkg::op_insert_word_128:
            begin
                next_vector = place(dest_operand, {48'h0, scalar_operand[15:0]}, 2,
                    {1'b0, word8_lane});
                next_vwrite = 1'b1;
            end
            simd_move_pkg::op_insert_byte:
            begin
                next_vector = place(dest_operand, scalar_operand, 1, byte_lane);
                next_vwrite = 1'b1;
            end
            simd_move_pkg::op_insert_dword,
            simd_move_pkg::op_insert_float:
            begin
                next_vector = place(dest_operand, scalar_operand, 4,
                    {2'b00, dword_lane});
                next_vwrite = 1'b1;
            end
            simd_move_pkg::op_insert_qword:
            begin
                next_vector = place(dest_operand, scalar_operand, 8,
                    {3'b000, qword_lane});
                next_vwrite = 1'b1;
            end
            simd_move_pkg::op_byte_mask_64,
            simd_move_pkg::op_byte_mask_128:
            begin
                next_scalar = {32'h0, sign_mask};
                next_swrite = 1'b1;
            end
            simd_move_pkg::word_shuffle_op:
            begin
                next_vector = {dest_operand[127:64], shuf_low};
                next_vwrite = 1'b1;
            end
            simd_move_pkg::low_word_shuffle_op:
            begin
                next_vector = {source_operand[127:64], shuf_low};
                next_vwrite = 1'b1;
            end
            simd_move_pkg::high_word_shuffle_op:
            begin
                next_vector = {shuf_high, source_operand[63:0]};
                next_vwrite = 1'b1;
            end
            simd_move_pkg::dword_shuffle_op:
            begin
                next_vector = shuf_dword;
                next_vwrite = 1'b1;
            end
            // Unknown codes write nothing and pass the destination through
            default:
            begin
                next_vector = dest_operand;
            end
        endcase
    end

    // Bundle the chosen result for the writeback stage
    assign next_if.vector = next_vector;
    assign next_if.scalar = next_scalar;
    assign next_if.vector_write = next_vwrite & issue_valid;
    assign next_if.scalar_write = next_swrite & issue_valid;

    // ------------------------------------------------------------------
    // Writeback stage
    // ------------------------------------------------------------------
    // Fixed one-cycle latency keeps the pipeline scoreboard simple
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            result_valid <= 1'b0;
            vector_write <= 1'b0;
            scalar_write <= 1'b0;
        end
        else if (clk_en)
        begin
            result_valid <= issue_valid;
            vector_write <= next_if.vector_write;
            scalar_write <= next_if.scalar_write;
        end
    end

    // Data loads even without an issue; only the write flags gate the
    // register file, which saves an enable term on the wide data flops
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            vector_result <= simd_move_pkg::RESULT_RESET;
            scalar_result <= simd_move_pkg::SCALAR_RESET;
        end
        else if (clk_en)
        begin
            vector_result <= next_if.vector;
            scalar_result <= next_if.scalar;
        end
    end
endmodule // simd_element_move_unit
`default_nettype wire

// ===== bench/simd_move_asserts.sv
// Checker: timing and datapath relations at the ports of the element move unit
`timescale 1ns/10ps
`default_nettype none
module simd_move_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Issue side
    input wire logic clk_en,
    input wire logic issue_valid,
    input wire simd_move_pkg::op_type op,
    input wire logic [7:0] control_byte,
    input wire logic [127:0] source_operand,
    // Writeback side
    input wire logic result_valid,
    input wire logic [127:0] vector_result,
    input wire logic [63:0] scalar_result,
    input wire logic vector_write,
    input wire logic scalar_write
);
    // ------------------------------------------------------------------
    // Helper decodes
    // ------------------------------------------------------------------
    // Reference picks built apart from the design so a wrong select shows up
    wire logic go;
    wire logic [15:0] msb_bits;
    wire logic [63:0] word_pick;
    wire logic [127:0] dword_pick;
    genvar i;
    for (i = 0; i < 16; i++)
    begin : g_msb
        assign msb_bits[i] = source_operand[8 * i + 7];
    end
    assign go = clk_en && issue_valid;
    assign word_pick = source_operand[63:0] >> {control_byte[1:0], 4'h0};
    assign dword_pick = source_operand >> {control_byte[1:0], 5'h0};
    default clocking main_clk @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_valid_next_cycle: assert property (go |=> result_valid)
        else $error("result_valid missing after an issue");
    a_idle_no_write: assert property (clk_en && !issue_valid |=>
        !result_valid && !vector_write && !scalar_write) else $error("write without an issue");
    a_freeze_holds: assert property (!clk_en |=> $stable(vector_result)
        && $stable(scalar_result) && $stable(result_valid)) else $error("output moved while frozen");
    a_extract_narrow: assert property (go && op == simd_move_pkg::op_extract_word_64 |=>
        scalar_write && scalar_result == {48'h0, $past(word_pick[15:0])})
        else $error("narrow word extract wrong");
    a_mask_narrow: assert property (go && op == simd_move_pkg::op_byte_mask_64 |=>
        scalar_result == {56'h0, $past(msb_bits[7:0])}) else $error("narrow byte mask wrong");
    a_mask_wide: assert property (go && op == simd_move_pkg::op_byte_mask_128 |=>
        scalar_result == {48'h0, $past(msb_bits)}) else $error("wide byte mask wrong");
    a_dword_lane_zero: assert property (go && op == simd_move_pkg::dword_shuffle_op |=>
        vector_write && vector_result[31:0] == $past(dword_pick[31:0]))
        else $error("dword shuffle lane 0 wrong");
    a_word_lane_zero: assert property (go && op == simd_move_pkg::word_shuffle_op |=>
        vector_result[15:0] == $past(word_pick[15:0])) else $error("word shuffle lane 0 wrong");
    a_low_half_pass: assert property (go && op == simd_move_pkg::low_word_shuffle_op |=>
        vector_result[127:64] == $past(source_operand[127:64])) else $error("upper half altered");
    a_high_half_pass: assert property (go && op == simd_move_pkg::high_word_shuffle_op |=>
        vector_result[63:0] == $past(source_operand[63:0])) else $error("lower half altered");
    // Main scenarios reached
    c_dword: cover property (go && op == simd_move_pkg::dword_shuffle_op);
    c_insert: cover property (go && op == simd_move_pkg::op_insert_word_64);
    c_frozen: cover property (!clk_en && result_valid);
endmodule // simd_move_asserts
bind simd_element_move_unit simd_move_asserts chk_u (.core_clk(core_clk), .resetn(resetn),
    .clk_en(clk_en), .issue_valid(issue_valid), .op(op), .control_byte(control_byte),
    .source_operand(source_operand), .result_valid(result_valid),
    .vector_result(vector_result), .scalar_result(scalar_result),
    .vector_write(vector_write), .scalar_write(scalar_write));
`default_nettype wire

// ===== bench/writeback_sink.sv
// Partner model: register-file writeback keeping the last results written
`timescale 1ns/10ps
`default_nettype none
module writeback_sink (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Results from the datapath
    input wire logic [127:0] vector_result,
    input wire logic [63:0] scalar_result,
    input wire logic vector_write,
    input wire logic scalar_write,
    // Register file contents
    output logic [127:0] vector_reg,
    output logic [63:0] scalar_reg
);
    // Only flagged results land, so stale data after a nop never overwrites
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            vector_reg <= 128'h0;
            scalar_reg <= 64'h0;
        end
        else
        begin
            if (vector_write)
                vector_reg <= vector_result;
            if (scalar_write)
                scalar_reg <= scalar_result;
        end
    end
endmodule // writeback_sink
`default_nettype wire

// ===== bench/simd_element_move_unit_tb_top.sv
// Testbench: scenario tasks for the SIMD element move unit
`timescale 1ns/10ps
`default_nettype none
module simd_element_move_unit_tb_top;
    // Stimulus and observed signals
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic issue_valid = 1'b0;
    simd_move_pkg::op_type op = simd_move_pkg::op_nop;
    simd_move_pkg::elem_type unpack_size = simd_move_pkg::elem_byte;
    logic [7:0] control_byte = 8'h00;
    logic [127:0] dest_operand = 128'h1e2d_3c4b_5a69_7887_0f1e_2d3c_4b5a_6978;
    logic [127:0] source_operand = 128'h8f7e_6d5c_4b3a_2918_f7e6_d5c4_b3a2_9180;
    logic [63:0] scalar_operand = 64'h0123_4567_89ab_cdef;
    logic result_valid, vector_write, scalar_write;
    logic [127:0] vector_result, vector_reg, exp, m;
    logic [63:0] scalar_result, scalar_reg;
    int fails = 0;
    int n_tests = 0;
    simd_element_move_unit dut_u (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
        .issue_valid(issue_valid), .op(op), .unpack_size(unpack_size),
        .control_byte(control_byte), .dest_operand(dest_operand),
        .source_operand(source_operand), .scalar_operand(scalar_operand),
        .result_valid(result_valid), .vector_result(vector_result),
        .scalar_result(scalar_result), .vector_write(vector_write), .scalar_write(scalar_write));
    writeback_sink sink_u (.core_clk(core_clk), .resetn(resetn), .vector_result(vector_result),
        .scalar_result(scalar_result), .vector_write(vector_write), .scalar_write(scalar_write),
        .vector_reg(vector_reg), .scalar_reg(scalar_reg));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [127:0] e, input logic [127:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    // Issue at a falling edge; issue_valid stays up so calls run back to back
    task automatic run(input simd_move_pkg::op_type o, input logic [7:0] c);
        op = o;
        control_byte = c;
        issue_valid = 1'b1;
        @(negedge core_clk);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_unpack();
        int w;
        for (int s = 0; s < 4; s++)
            for (int h = 0; h < 2; h++)
            begin
                w = 8 << s;
                unpack_size = simd_move_pkg::elem_type'(s);
                run(h ? simd_move_pkg::op_unpack_high : simd_move_pkg::op_unpack_low, 8'h00);
                for (int b = 0; b < 64; b++)
                begin
                    exp[2 * w * (b / w) + b % w] = dest_operand[64 * h + b];
                    exp[2 * w * (b / w) + w + b % w] = source_operand[64 * h + b];
                end
                check("unpack", exp, vector_result);
            end
    endtask
    // Upper control bits are set everywhere to show they are ignored
    task automatic t_extract();
        simd_move_pkg::op_type ops [6] = '{simd_move_pkg::op_extract_word_64,
            simd_move_pkg::op_extract_word_128, simd_move_pkg::op_extract_byte,
            simd_move_pkg::op_extract_dword, simd_move_pkg::op_extract_qword,
            simd_move_pkg::op_extract_float};
        int wid [6] = '{16, 16, 8, 32, 64, 32};
        int lane [6] = '{2, 5, 11, 2, 1, 1};
        logic [7:0] cbs [6] = '{8'hfe, 8'hfd, 8'hfb, 8'hfe, 8'hff, 8'hfd};
        for (int k = 0; k < 6; k++)
        begin
            run(ops[k], cbs[k]);
            m = (128'h1 << wid[k]) - 128'h1;
            exp = (source_operand >> (wid[k] * lane[k])) & m;
            check("extract", exp, {64'h0, scalar_result});
            check("extract write", 128'h1, {127'h0, scalar_write});
        end
    endtask
    task automatic t_insert();
        simd_move_pkg::op_type ops [6] = '{simd_move_pkg::op_insert_word_64,
            simd_move_pkg::op_insert_word_128, simd_move_pkg::op_insert_byte,
            simd_move_pkg::op_insert_dword, simd_move_pkg::op_insert_qword,
            simd_move_pkg::op_insert_float};
        int wid [6] = '{16, 16, 8, 32, 64, 32};
        int lane [6] = '{1, 6, 3, 2, 1, 1};
        logic [7:0] cbs [6] = '{8'hfd, 8'hfe, 8'hf3, 8'hfe, 8'hff, 8'hfd};
        for (int k = 0; k < 6; k++)
        begin
            run(ops[k], cbs[k]);
            m = ((128'h1 << wid[k]) - 128'h1) << (wid[k] * lane[k]);
            exp = (dest_operand & ~m) | (({64'h0, scalar_operand} << (wid[k] * lane[k])) & m);
            check("insert", exp, vector_result);
        end
        issue_valid = 1'b0;
        @(negedge core_clk);
        check("register file", exp, vector_reg);
    endtask
    task automatic t_mask();
        for (int h = 0; h < 2; h++)
        begin
            run(h ? simd_move_pkg::op_byte_mask_128 : simd_move_pkg::op_byte_mask_64, 8'h00);
            exp = 128'h0;
            for (int b = 0; b < 8 + 8 * h; b++)
                exp[b] = source_operand[8 * b + 7];
            check("byte mask", exp, {64'h0, scalar_result});
        end
    endtask
    task automatic t_shuffle();
        simd_move_pkg::op_type ops [4] = '{simd_move_pkg::word_shuffle_op,
            simd_move_pkg::low_word_shuffle_op, simd_move_pkg::high_word_shuffle_op,
            simd_move_pkg::dword_shuffle_op};
        logic [7:0] c;
        for (int n = 0; n < 2; n++)
            for (int o = 0; o < 4; o++)
            begin
                c = n ? 8'h9c : 8'h1b;
                run(ops[o], c);
                exp = (o == 0) ? dest_operand : source_operand;
                for (int k = 0; k < 4; k++)
                    if (o == 3)
                        exp[32 * k +: 32] = source_operand[32 * c[2 * k +: 2] +: 32];
                    else
                        exp[64 * (o / 2) + 16 * k +: 16] =
                            source_operand[64 * (o / 2) + 16 * c[2 * k +: 2] +: 16];
                check("shuffle", exp, vector_result);
            end
    endtask
    // A frozen enable must hold the last result even with a new issue waiting
    task automatic t_flow();
        run(simd_move_pkg::op_nop, 8'h00);
        check("nop writes", 128'h0, {126'h0, vector_write, scalar_write});
        run(simd_move_pkg::dword_shuffle_op, 8'h1b);
        exp = {source_operand[31:0], source_operand[63:32], source_operand[95:64],
            source_operand[127:96]};
        clk_en = 1'b0;
        op = simd_move_pkg::op_byte_mask_128;
        repeat (2) @(negedge core_clk);
        check("frozen result", exp, vector_result);
        clk_en = 1'b1;
        issue_valid = 1'b0;
        @(negedge core_clk);
        check("idle valid", 128'h0, {127'h0, result_valid});
    endtask
    // ------------------------------------------------------------------
    // Clock, main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (10) @(negedge core_clk);
        check("reset result", simd_move_pkg::RESULT_RESET, vector_result);
        resetn = 1'b1;
        t_unpack();
        t_extract();
        t_insert();
        t_mask();
        t_shuffle();
        t_flow();
        close_out();
    end
    // The sequence needs under 100 cycles; 10000 leaves ample margin
    initial
    begin
        #100000;
        fails++;
        close_out();
    end
endmodule // simd_element_move_unit_tb_top
`default_nettype wire
